// ===== hw/wdt_pkg.sv
// Package for the engine watchdog timer: register map, field layout, constants.
// Assumes a 32-bit APB register bus with word-aligned registers.
package wdt_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
	localparam int unsigned MODE_BIT = 31;
	localparam logic [30:0] CTL_ENABLE_CODE = 31'h00000000;
	localparam logic [30:0] CTL_DISABLE_CODE = 31'h00000001;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h00000001;
	localparam logic [DATA_W-1:0] LIMIT_RESET = 32'hFFFFFFFF;
	localparam int unsigned IRQ_WDOG_BIT = 6;
	localparam logic [DATA_W-1:0] IRQ_USED_MASK = 32'h00000040;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] control;
		logic [DATA_W-1:0] limit;
	} wdt_ctx_t;
endpackage

// ===== hw/wdt_counter.sv
// Watchdog count register with threshold compare.
// Assumes single clock domain; tick and enables are synchronous.
`timescale 1ns/1ns
module wdt_counter import wdt_pkg::*; #(
	parameter int unsigned WIDTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_enable,
	input wire logic i_gate,
	input wire logic i_tick,
	input wire logic [WIDTH-1:0] i_limit,
	output logic [WIDTH-1:0] o_count,
	output logic o_match
);
	initial begin
		if (WIDTH < 2 || WIDTH > DATA_W) $error("wdt_counter WIDTH out of range");
	end

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;
	wire match_w = i_enable && (count_q == i_limit);

	always_comb begin
		count_d = count_q;
		if (!i_enable) begin
			count_d = '0;
		end else if (match_w) begin
			count_d = '0;
		end else if (i_gate && i_tick) begin
			count_d = count_q + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign o_count = count_q;
	assign o_match = match_w;

	disable_clears_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!i_enable |=> count_q == '0) else $error("count not cleared while disabled");
	match_clears_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		match_w |=> count_q == '0) else $error("count not cleared on match");
	no_gate_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_enable && !match_w && !(i_gate && i_tick)) |=> $stable(count_q))
		else $error("count moved without gate and tick");
endmodule

// ===== hw/engine_context_watchdog_timer.sv
// Engine watchdog timer with APB register access and context save/restore port.
// Assumes APB master on i_ref_clk; timestamp toggle, context valid and list
// submission enable are synchronous levels from the engine.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module engine_context_watchdog_timer import wdt_pkg::*; #(
	parameter int unsigned COUNT_W = 32
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [DATA_W-1:0] i_pwdata,
	output logic [DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Engine status
	input wire logic i_timestamp,
	input wire logic i_ctx_valid,
	input wire logic i_execlist_en,
	// Context image
	input wire logic i_ctx_restore,
	input wire wdt_ctx_t i_ctx_image,
	output wdt_ctx_t o_ctx_image,
	// Interrupt
	output logic o_irq
);
	initial begin
		if (COUNT_W != DATA_W) $error("COUNT_W must equal the register width");
	end

	apb_req_t req;
	assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};

	logic [DATA_W-1:0] control_q;
	logic [DATA_W-1:0] limit_q;
	logic enabled_q;
	logic [DATA_W-1:0] irq_status_q;
	logic [DATA_W-1:0] irq_mask_q;
	logic ts_q;
	logic [DATA_W-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	wdt_ctx_t ctx_q;
	logic [COUNT_W-1:0] count_w;
	logic match_w;

	// Zero-wait access: one setup, one access cycle, response registered on the setup edge
	wire access_w = req.psel && req.penable;
	wire wr_w = access_w && req.pwrite;
	wire hit_ctl_w = req.paddr == OFF_CONTROL;
	wire hit_lim_w = req.paddr == OFF_LIMIT;
	wire hit_cnt_w = req.paddr == OFF_COUNT;
	wire hit_sts_w = req.paddr == OFF_IRQ_STATUS;
	wire hit_msk_w = req.paddr == OFF_IRQ_MASK;
	wire mapped_w = hit_ctl_w || hit_lim_w || hit_cnt_w || hit_sts_w || hit_msk_w;
	wire wr_ro_w = req.pwrite && hit_cnt_w;
	wire err_w = !mapped_w || wr_ro_w;
	wire wr_ctl_w = wr_w && hit_ctl_w;
	wire wr_lim_w = wr_w && hit_lim_w;
	wire wr_sts_w = wr_w && hit_sts_w;
	wire wr_msk_w = wr_w && hit_msk_w;

	// Control word source: software write, else context restore
	wire ctl_load_w = wr_ctl_w || i_ctx_restore;
	wire [DATA_W-1:0] ctl_new_w = wr_ctl_w ? req.pwdata : i_ctx_image.control;
	wire [DATA_W-1:0] lim_new_w = wr_lim_w ? req.pwdata : i_ctx_image.limit;
	wire ctl_is_en_w = ctl_new_w[30:0] == CTL_ENABLE_CODE;
	wire ctl_is_dis_w = ctl_new_w[30:0] == CTL_DISABLE_CODE;
	wire enabled_d = !ctl_load_w ? enabled_q : ctl_is_en_w ? 1'b1 : ctl_is_dis_w ? 1'b0 : enabled_q;

	// Tick source chosen by mode bit
	wire ts_toggle_w = i_timestamp != ts_q;
	wire tick_w = control_q[MODE_BIT] ? 1'b1 : ts_toggle_w;
	wire gate_w = i_ctx_valid && i_execlist_en;

	wire [DATA_W-1:0] wdog_evt_w = match_w ? IRQ_USED_MASK : '0;
	wire [DATA_W-1:0] sts_clr_w = wr_sts_w ? req.pwdata : '0;
	// Set wins over a simultaneous write-one-to-clear
	wire [DATA_W-1:0] irq_status_d = ((irq_status_q & ~sts_clr_w) | wdog_evt_w) & IRQ_USED_MASK;
	wire irq_d = |(irq_status_d & irq_mask_q);

	wire [DATA_W-1:0] rd_mux_w = hit_ctl_w ? control_q :
		hit_lim_w ? limit_q :
		hit_cnt_w ? count_w :
		hit_sts_w ? irq_status_q :
		hit_msk_w ? irq_mask_q : '0;

	wdt_counter #(.WIDTH(COUNT_W)) u_counter (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_enable(enabled_q),
		.i_gate(gate_w),
		.i_tick(tick_w),
		.i_limit(limit_q),
		.o_count(count_w),
		.o_match(match_w)
	);

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			control_q <= CONTROL_RESET;
			limit_q <= LIMIT_RESET;
			enabled_q <= 1'b0;
		end else begin
			if (ctl_load_w) control_q <= ctl_new_w;
			if (wr_lim_w || i_ctx_restore) limit_q <= lim_new_w;
			enabled_q <= enabled_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_status_q <= '0;
			irq_mask_q <= '0;
			irq_q <= 1'b0;
			ts_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			if (wr_msk_w) irq_mask_q <= req.pwdata & IRQ_USED_MASK;
			irq_q <= irq_d;
			ts_q <= i_timestamp;
		end
	end

	// Context image carries control and limit only; the count stays out
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctx_q <= '{control: CONTROL_RESET, limit: LIMIT_RESET};
		end else begin
			ctx_q <= '{control: control_q, limit: limit_q};
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= req.psel && !req.penable;
			pslverr_q <= req.psel && !req.penable && err_w;
			prdata_q <= (req.psel && !req.penable && !req.pwrite) ? rd_mux_w : '0;
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_irq = irq_q;
	assign o_ctx_image = ctx_q;

	enable_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(wr_ctl_w && req.pwdata[30:0] == CTL_ENABLE_CODE) |=> enabled_q)
		else $error("enable code did not enable");
	disable_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(wr_ctl_w && req.pwdata[30:0] == CTL_DISABLE_CODE) |=> !enabled_q ##1 count_w == '0)
		else $error("disable code did not stop and clear");
	other_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(wr_ctl_w && !i_ctx_restore && req.pwdata[30:0] > CTL_DISABLE_CODE) |=> $stable(enabled_q))
		else $error("other code changed enable");
	clock_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(enabled_q && control_q[MODE_BIT] && gate_w && !match_w) |=> count_w == $past(count_w) + 1'b1)
		else $error("clock mode did not count");
	toggle_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(enabled_q && !control_q[MODE_BIT] && !ts_toggle_w && !match_w) |=> $stable(count_w))
		else $error("timestamp mode counted without toggle");
	match_irq_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		match_w |=> irq_status_q[IRQ_WDOG_BIT] ##0 count_w == '0)
		else $error("match did not raise status");
	gate_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(enabled_q && !gate_w && !match_w) |=> $stable(count_w))
		else $error("counted without context");
	ctx_image_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_ctx_restore && !wr_w |=> control_q == $past(i_ctx_image.control) && limit_q == $past(i_ctx_image.limit))
		else $error("context restore failed");
	// Judged on the next status value, so a clear in the same cycle does not trip it
	irq_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(|(irq_status_d & irq_mask_q)) |=> o_irq)
		else $error("irq not raised");

	match_seen_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) match_w);
	irq_seen_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) o_irq);
	restore_seen_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) i_ctx_restore ##1 enabled_q);
	toggle_count_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
		enabled_q && !control_q[MODE_BIT] && ts_toggle_w && gate_w);
endmodule

// ===== verification/engine_context_watchdog_timer_test.sv
// Self-checking bench for the engine watchdog timer, with an integer model of the count.
// Assumes the zero-wait APB slave and the one-cycle enable latency of the design.
`timescale 1ns/1ns
module engine_context_watchdog_timer_test import wdt_pkg::*;;
	logic ref_clk, resetn, psel, penable, pwrite, ts, ctx_valid, execlist_en, ctx_restore, pready, pslverr, irq, err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdata;
	wdt_ctx_t img_in, img_out;
	int mismatches = 0;
	int checked = 0;
	int seed = 32'hECD85942;
	int cnt_m, lim_m, st_m, n, mode;

	engine_context_watchdog_timer dut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_timestamp(ts), .i_ctx_valid(ctx_valid), .i_execlist_en(execlist_en),
		.i_ctx_restore(ctx_restore), .i_ctx_image(img_in), .o_ctx_image(img_out), .o_irq(irq));

	task automatic wrap_up();
		if (mismatches == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Idle cycle after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			mismatches++;
			wrap_up();
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h00000000);
		chk(nm, exp, rdata);
	endtask

	// Opens both gates for k ticks; in timestamp mode idle edges follow each toggle,
	// so a match clears the count before the next tick rather than consuming one
	task automatic run(input int k);
		ctx_valid <= 1'b1;
		execlist_en <= 1'b1;
		if (mode == 1) repeat (k) @(posedge ref_clk);
		else begin
			repeat (2) @(posedge ref_clk);
			repeat (k) begin
				ts <= ~ts;
				repeat (3) @(posedge ref_clk);
			end
		end
		ctx_valid <= 1'b0;
		execlist_en <= 1'b0;
		@(posedge ref_clk);
		repeat (k) begin
			if (mode == 1 && cnt_m == lim_m) cnt_m = 0;
			else cnt_m++;
			if (mode == 0 && cnt_m == lim_m) cnt_m = 0;
			if (cnt_m == 0) st_m = 1;
		end
		if (cnt_m == lim_m) begin
			cnt_m = 0;
			st_m = 1;
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial begin
		{resetn, psel, penable, pwrite, ts, ctx_valid, execlist_en, ctx_restore} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		img_in = 64'h0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(OFF_CONTROL, CONTROL_RESET, "control");
		rd(OFF_LIMIT, LIMIT_RESET, "limit");
		rd(OFF_COUNT, 32'h00000000, "count");
		rd(8'h14, 32'h00000000, "unmapped");
		chk("unmapped_err", 32'h00000001, {31'h0, err});
		apb(1'b1, OFF_COUNT, 32'h00000005);
		chk("count_err", 32'h00000001, {31'h0, err});
		for (int it = 0; it < 4; it++) begin
			mode = it % 2;
			lim_m = 3 + ($random(seed) & 7);
			n = 4 + ($random(seed) & 15);
			cnt_m = 0;
			st_m = 0;
			apb(1'b1, OFF_IRQ_MASK, (it > 1) ? 32'h00000040 : 32'h00000000);
			apb(1'b1, OFF_LIMIT, 32'(lim_m));
			apb(1'b1, OFF_CONTROL, {mode[0], 31'h0});
			run(n);
			rd(OFF_COUNT, 32'(cnt_m), "count_run");
			rd(OFF_IRQ_STATUS, (st_m != 0) ? 32'h00000040 : 32'h00000000, "status");
			chk("irq", {31'h0, st_m != 0 && it > 1}, {31'h0, irq});
			chk("image_ctl", {mode[0], 31'h0}, img_out.control);
			apb(1'b1, OFF_IRQ_STATUS, 32'h00000040);
			rd(OFF_IRQ_STATUS, 32'h00000000, "status_clr");
			apb(1'b1, OFF_CONTROL, {mode[0], 31'h1});
			rd(OFF_COUNT, 32'h00000000, "count_off");
		end
		apb(1'b1, OFF_LIMIT, 32'h00000100);
		apb(1'b1, OFF_CONTROL, 32'h80000000);
		ctx_valid <= 1'b1;
		repeat (8) @(posedge ref_clk);
		ctx_valid <= 1'b0;
		execlist_en <= 1'b1;
		repeat (8) @(posedge ref_clk);
		execlist_en <= 1'b0;
		rd(OFF_COUNT, 32'h00000000, "count_gated");
		mode = 1;
		lim_m = 256;
		cnt_m = 0;
		run(5);
		// Neither code: enable must hold and the whole word is stored, clearing the mode bit and setting bit 1
		apb(1'b1, OFF_CONTROL, 32'h00000002);
		rd(OFF_COUNT, 32'(cnt_m), "count_held");
		mode = 0;
		run(2);
		rd(OFF_COUNT, 32'(cnt_m), "count_mode0");
		img_in <= {32'h80000000, 32'h00000123};
		ctx_restore <= 1'b1;
		@(posedge ref_clk);
		ctx_restore <= 1'b0;
		@(posedge ref_clk);
		rd(OFF_CONTROL, 32'h80000000, "ctl_restored");
		rd(OFF_LIMIT, 32'h00000123, "lim_restored");
		rd(OFF_COUNT, 32'(cnt_m), "count_kept");
		chk("image_lim", 32'h00000123, img_out.limit);
		wrap_up();
	end
endmodule
